// ===== verilog/spp_pkg.sv
/*
  package for the shared pin port: register offsets, field layout,
  reset values and the output routing source codes.
  assumes a 32-bit apb bus with word aligned registers.
*/
`default_nettype none
package spp_pkg;
  // ************************************************************
  // port geometry
  // ************************************************************
  localparam int unsigned PINS = 16;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned SRC_N = 31;
  localparam int unsigned NUM_REMAP = 4;
  localparam logic [15:0] IMPL_MASK = 16'hFFFF;
  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] DIR_OFS = 8'h00;
  localparam logic [7:0] LAT_OFS = 8'h04;
  localparam logic [7:0] LVL_OFS = 8'h08;
  localparam logic [7:0] RISE_OFS = 8'h0C;
  localparam logic [7:0] FALL_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam logic [7:0] CTRL_OFS = 8'h18;
  localparam logic [7:0] SEL0_OFS = 8'h1C;
  localparam logic [7:0] SEL1_OFS = 8'h20;
  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int unsigned SEL_HI_POS = 8;
  localparam int unsigned CTRL_ON_POS = 0;
  localparam int unsigned CTRL_FLAG_POS = 1;
  localparam logic [15:0] DIR_RST = 16'hFFFF;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [5:0] SEL_NONE = 6'h00;
  localparam logic [5:0] SRC_CMP1 = 6'h01;
  localparam logic [5:0] SRC_SER1_TX = 6'h03;
  localparam logic [5:0] SRC_CMP_OUT1 = 6'h0D;
  localparam logic [5:0] SRC_LCELL2 = 6'h1E;
endpackage
`default_nettype wire

// ===== verilog/spp_route.sv
/*
  output routing for one remappable pin: picks a peripheral output by
  its select code, or nothing for code zero.
  assumes peripheral outputs and enables arrive indexed by source code.
*/
`timescale 1ns/10ps
`default_nettype none
module spp_route (
  // select code
  input wire logic [5:0] sel,
  // peripheral sources, index is the source code
  input wire logic [30:0] src_out,
  input wire logic [30:0] src_drive,
  // routed result
  output logic pin_out,
  output logic pin_drive
);
  // ************************************************************
  // source select
  // ************************************************************
  // code zero and codes beyond the table leave the pin to the port
  always_comb begin
    pin_out = 1'b0;
    pin_drive = 1'b0;
    if (sel != spp_pkg::SEL_NONE && sel < 6'(spp_pkg::SRC_N)) begin
      pin_out = src_out[5'(sel)];
      pin_drive = src_drive[5'(sel)];
    end
  end
endmodule
`default_nettype wire

// ===== verilog/spp_port.sv
/*
  shared pin port: direction, latch and level registers, peripheral
  ownership of outputs, edge change detection and output routing.
  assumes apb master, pins synchronous to ref_clk, 40 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
// Function
// - per pin muxes choose peripheral or port for data and enable
// - an actively driving peripheral disables the port driver; level still readable
// - enabled but idle peripheral lets the port drive by direction and latch
// - port output never loops back into the sharing peripheral input
// - direction bit one makes an input, zero an output
// - reset sets all direction bits so every pin is an input
// - latch register reads the latch, writes update it
// - level register reads pins, writes go to the latch
// - unimplemented bits read zero in latch, direction and level
// - pins with input only sharers stay full port pins
// - rise enable makes low to high set status and flag
// - fall enable makes high to low set status and flag
// - both enables catch any edge, neither disables detection
// - each select register holds two six bit pin fields
// - field value picks the peripheral output for the pin
// - field zero leaves the pin with the port
module spp_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fixed peripherals sharing each pin
  input wire logic [15:0] periph_en,
  input wire logic [15:0] periph_drive,
  input wire logic [15:0] periph_out,
  output logic [15:0] periph_in,
  // routable peripheral outputs, index is source code
  input wire logic [30:0] src_out,
  input wire logic [30:0] src_drive,
  // pad
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  // change notice
  output logic change_flag
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] masked(input logic [15:0] v);
    masked = v & spp_pkg::IMPL_MASK;
  endfunction

  function automatic logic [15:0] merge_be(input logic [15:0] old, input logic [31:0] wd);
    merge_be = masked(wd[15:0]);
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0] dir_q, lat_q, rise_q, fall_q, stat_q;
  logic on_q, flag_q;
  logic [5:0] sel_q [spp_pkg::NUM_REMAP];
  logic [15:0] sync1, sync2, prev_q;
  logic [15:0] next_dir, next_lat, next_rise, next_fall, next_stat;
  logic next_on, next_flag;
  logic [5:0] next_sel [spp_pkg::NUM_REMAP];
  logic [31:0] next_prdata;
  logic next_pready;
  logic [15:0] edge_hit;
  logic wr_acc, rd_setup, known;

  // apb phases: a write lands at the access edge that sees pready high
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;

  // edges from the second synchroniser stage against the previous sample
  assign edge_hit = on_q ? ((sync2 & ~prev_q & rise_q) | (~sync2 & prev_q & fall_q))
                         : 16'h0000;

  // ************************************************************
  // register next values and read mux
  // ************************************************************
  // read data is prepared in the setup cycle so it stands with pready
  always_comb begin
    next_dir = dir_q;
    next_lat = lat_q;
    next_rise = rise_q;
    next_fall = fall_q;
    next_on = on_q;
    next_sel = sel_q;
    next_stat = stat_q;
    next_flag = flag_q;
    next_prdata = prdata;
    next_pready = rd_setup;
    known = 1'b1;
    case (paddr)
      spp_pkg::DIR_OFS: next_prdata = {16'h0000, masked(dir_q)};
      spp_pkg::LAT_OFS: next_prdata = {16'h0000, masked(lat_q)};
      spp_pkg::LVL_OFS: next_prdata = {16'h0000, masked(sync2)};
      spp_pkg::RISE_OFS: next_prdata = {16'h0000, rise_q};
      spp_pkg::FALL_OFS: next_prdata = {16'h0000, fall_q};
      spp_pkg::STAT_OFS: next_prdata = {16'h0000, stat_q};
      spp_pkg::CTRL_OFS: next_prdata = {30'h00000000, flag_q, on_q};
      spp_pkg::SEL0_OFS: next_prdata = {18'h00000, sel_q[1], 2'h0, sel_q[0]};
      spp_pkg::SEL1_OFS: next_prdata = {18'h00000, sel_q[3], 2'h0, sel_q[2]};
      default: begin
        next_prdata = 32'h00000000;
        known = 1'b0;
      end
    endcase
    if (!rd_setup || pwrite) begin
      next_prdata = prdata;
    end
    if (wr_acc) begin
      case (paddr)
        spp_pkg::DIR_OFS: next_dir = merge_be(dir_q, pwdata);
        spp_pkg::LAT_OFS: next_lat = merge_be(lat_q, pwdata);
        spp_pkg::LVL_OFS: next_lat = merge_be(lat_q, pwdata);
        spp_pkg::RISE_OFS: next_rise = masked(pwdata[15:0]);
        spp_pkg::FALL_OFS: next_fall = masked(pwdata[15:0]);
        spp_pkg::STAT_OFS: next_stat = stat_q & ~pwdata[15:0];
        spp_pkg::CTRL_OFS: begin
          next_on = pwdata[spp_pkg::CTRL_ON_POS];
          next_flag = flag_q & ~pwdata[spp_pkg::CTRL_FLAG_POS];
        end
        spp_pkg::SEL0_OFS: begin
          next_sel[0] = pwdata[5:0];
          next_sel[1] = pwdata[spp_pkg::SEL_HI_POS +: 6];
        end
        spp_pkg::SEL1_OFS: begin
          next_sel[2] = pwdata[5:0];
          next_sel[3] = pwdata[spp_pkg::SEL_HI_POS +: 6];
        end
        default: next_on = on_q;
      endcase
    end
    // a new edge wins over a clear in the same cycle
    next_stat = next_stat | edge_hit;
    if (edge_hit != 16'h0000) begin
      next_flag = 1'b1;
    end
  end

  // unmapped addresses answer with an error beside pready
  logic next_slverr;
  assign next_slverr = rd_setup && !known;

  // software state and the bus answer, all registered on one edge
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dir_q <= spp_pkg::DIR_RST;
      lat_q <= spp_pkg::ZERO16;
      rise_q <= spp_pkg::ZERO16;
      fall_q <= spp_pkg::ZERO16;
      stat_q <= spp_pkg::ZERO16;
      on_q <= 1'b0;
      flag_q <= 1'b0;
      for (int i = 0; i < spp_pkg::NUM_REMAP; i++) begin
        sel_q[i] <= spp_pkg::SEL_NONE;
      end
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      dir_q <= next_dir;
      lat_q <= next_lat;
      rise_q <= next_rise;
      fall_q <= next_fall;
      stat_q <= next_stat;
      on_q <= next_on;
      flag_q <= next_flag;
      sel_q <= next_sel;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_slverr;
    end
  end

  // ************************************************************
  // pin sampling
  // ************************************************************
  // two stages before use; edges compare stage two with its last value
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
      prev_q <= 16'h0000;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
      prev_q <= sync2;
    end
  end

  // ************************************************************
  // output ownership
  // ************************************************************
  logic [3:0] rt_out, rt_drive;
  for (genvar g = 0; g < spp_pkg::NUM_REMAP; g++) begin : g_route
    spp_route u_route (
      .sel(sel_q[g]),
      .src_out(src_out),
      .src_drive(src_drive),
      .pin_out(rt_out[g]),
      .pin_drive(rt_drive[g])
    );
  end

  logic [15:0] own_out, own_drive, next_pad_out, next_pad_oe, next_pin_in;
  // each source is gated by its own drive so an idle one cannot mask the other
  assign own_out = {periph_out[15:4],
                    (periph_out[3:0] & periph_en[3:0] & periph_drive[3:0])
                    | (rt_out & rt_drive)};
  assign own_drive = {periph_en[15:4] & periph_drive[15:4],
                      (periph_en[3:0] & periph_drive[3:0]) | rt_drive};

  // peripheral takes the pin only while actively driving; otherwise port
  always_comb begin
    for (int i = 0; i < spp_pkg::PINS; i++) begin
      if (own_drive[i]) begin
        next_pad_out[i] = own_out[i];
        next_pad_oe[i] = 1'b1;
      end else begin
        next_pad_out[i] = lat_q[i];
        next_pad_oe[i] = ~dir_q[i] & spp_pkg::IMPL_MASK[i];
      end
      // while the port drives, the peripheral sees zero, not its own latch
      next_pin_in[i] = (next_pad_oe[i] && !own_drive[i]) ? 1'b0 : sync2[i];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_out <= 16'h0000;
      pad_oe <= 16'h0000;
      periph_in <= 16'h0000;
      change_flag <= 1'b0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
      periph_in <= next_pin_in;
      change_flag <= next_flag;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // registered outputs are checked one edge after their cause, except change_flag in rise_set_a, checked two edges after
  dir_reset_a: assert property (@(posedge ref_clk)
    $rose(rst_sync_n) |-> dir_q == spp_pkg::DIR_RST)
    else $error("direction not all inputs after reset");
  input_off_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (dir_q[0] && !own_drive[0]) |=> !pad_oe[0])
    else $error("input pin driven");
  periph_own_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    own_drive != 16'h0000 |=> ((pad_oe & $past(own_drive)) == $past(own_drive))
      && ((pad_out & $past(own_drive)) == ($past(own_out) & $past(own_drive))))
    else $error("peripheral lost pin");
  rise_set_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (on_q && rise_q[8] && sync2[8] && !prev_q[8]) |=> stat_q[8] ##1 change_flag)
    else $error("rising edge missed");
  fall_set_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (on_q && fall_q[9] && !sync2[9] && prev_q[9]) |=> stat_q[9] && change_flag)
    else $error("falling edge missed");
  off_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (!on_q || (rise_q == 16'h0000 && fall_q == 16'h0000)) |-> edge_hit == 16'h0000)
    else $error("edge with detection off");
  lat_write_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_acc && paddr == spp_pkg::LVL_OFS) |=> lat_q == $past(pwdata[15:0]))
    else $error("level write missed latch");
  loop_block_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (!dir_q[2] && !own_drive[2]) |=> !periph_in[2])
    else $error("port output looped to peripheral");
  null_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    sel_q[0] == spp_pkg::SEL_NONE |-> !rt_drive[0])
    else $error("null select drives pin");
  cv_rise_c: cover property (@(posedge ref_clk) edge_hit[8] && rise_q[8]);
  cv_fall_c: cover property (@(posedge ref_clk) edge_hit[9] && fall_q[9]);
  cv_remap_c: cover property (@(posedge ref_clk) rt_drive[0] && sel_q[0] == 6'h03);
  cv_write_c: cover property (@(posedge ref_clk) wr_acc && paddr == spp_pkg::LAT_OFS);
endmodule
`default_nettype wire

// ===== verification/spp_far_model.sv
/*
  far side model: the board level on each pin and the resolved pad level.
  assumes pad_oe high means the port or a fixed or routed peripheral drives the pin.
*/
`timescale 1ns/10ps
`default_nettype none
module spp_far_model (
  // from the port
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  // board drive
  input wire logic [15:0] board_level,
  // to the port
  output logic [15:0] pad_in
);
  // a driven pin shows the driven value, an undriven one the board level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_level);
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
/*
  testbench for the shared pin port: apb tasks and directed sequences.
  assumes the port answers each apb request within twenty cycles and
  fixed pin sync delays of the port.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] periph_en = 16'h0;
  logic [15:0] periph_drive = 16'h0;
  logic [15:0] periph_out = 16'h0;
  logic [15:0] periph_in;
  logic [30:0] src_out = 31'h0;
  logic [30:0] src_drive = 31'h0;
  logic [15:0] pad_in;
  logic [15:0] pad_out;
  logic [15:0] pad_oe;
  logic change_flag;
  logic [15:0] board_level = 16'h0;
  logic [31:0] rdata;
  logic rerr;
  int mismatches = 0;
  int check_count = 0;
  int codes [4] = '{1, 3, 13, 30};

  always #12.5 ref_clk = ~ref_clk;

  spp_port spp_port_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_en(periph_en), .periph_drive(periph_drive),
    .periph_out(periph_out), .periph_in(periph_in), .src_out(src_out),
    .src_drive(src_drive), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .change_flag(change_flag));

  spp_far_model spp_far_model_inst (.pad_out(pad_out), .pad_oe(pad_oe),
    .board_level(board_level), .pad_in(pad_in));

  // ************************************************************
  // reporting
  // ************************************************************
  task automatic summarize();
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ************************************************************
  // apb master
  // ************************************************************
  // request held from setup until pready is sampled high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, rdata, exp);
  endtask

  // one board edge, then status and flag compared and cleared
  task automatic edge_case(input int pin, input logic val, input logic hit);
    board_level[pin] <= val;
    repeat (6) @(posedge ref_clk);
    rchk("status", spp_pkg::STAT_OFS, hit ? (32'h1 << pin) : 32'h0);
    chk("flag", {31'h0, change_flag}, {31'h0, hit});
    xfer(1'b1, spp_pkg::STAT_OFS, 32'h0000FFFF);
    xfer(1'b1, spp_pkg::CTRL_OFS, 32'h00000003);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("oe_rst", {16'h0, pad_oe}, 32'h0);
    rchk("dir_rst", spp_pkg::DIR_OFS, 32'h0000FFFF);
    rchk("rise_rst", spp_pkg::RISE_OFS, 32'h0);
    rchk("fall_rst", spp_pkg::FALL_OFS, 32'h0);
    // level write lands in the latch
    xfer(1'b1, spp_pkg::LVL_OFS, 32'h000000A5);
    rchk("lat", spp_pkg::LAT_OFS, 32'h000000A5);
    board_level <= 16'h5A00;
    xfer(1'b1, spp_pkg::DIR_OFS, 32'h0000FF00);
    repeat (3) @(posedge ref_clk);
    chk("oe", {16'h0, pad_oe}, 32'h000000FF);
    chk("out", {24'h0, pad_out[7:0]}, 32'h000000A5);
    rchk("lvl", spp_pkg::LVL_OFS, 32'h00005AA5);
    chk("fedback", {16'h0, periph_in}, 32'h00005A00);
    // fixed peripheral on pin 2: idle, then driving low
    periph_en <= 16'h0004;
    repeat (3) @(posedge ref_clk);
    chk("idle_per", {30'h0, pad_oe[2], pad_out[2]}, 32'h3);
    periph_drive <= 16'h0004;
    repeat (3) @(posedge ref_clk);
    chk("per_drv", {30'h0, pad_oe[2], pad_out[2]}, 32'h2);
    rchk("per_lvl", spp_pkg::LVL_OFS, 32'h00005AA1);
    periph_en <= 16'h0;
    periph_drive <= 16'h0;
    // routed sources on pins 0 and 3, fields of code zero stay with the port
    src_drive <= '1;
    foreach (codes[i]) begin
      src_out <= ~(31'h1 << codes[i]);
      xfer(1'b1, spp_pkg::SEL0_OFS, 32'(codes[i]));
      xfer(1'b1, spp_pkg::SEL1_OFS, 32'(codes[i]) << spp_pkg::SEL_HI_POS);
      repeat (3) @(posedge ref_clk);
      chk("route", {28'h0, pad_out[3:0]}, 32'h4);
    end
    src_drive <= '0;
    // enables set while detection is off, so no stray event
    xfer(1'b1, spp_pkg::RISE_OFS, 32'h00000900);
    xfer(1'b1, spp_pkg::FALL_OFS, 32'h00000A00);
    xfer(1'b1, spp_pkg::CTRL_OFS, 32'h00000003);
    xfer(1'b1, spp_pkg::STAT_OFS, 32'h0000FFFF);
    edge_case(8, 1'b1, 1'b1);
    edge_case(8, 1'b0, 1'b0);
    edge_case(9, 1'b0, 1'b1);
    edge_case(9, 1'b1, 1'b0);
    edge_case(11, 1'b0, 1'b1);
    edge_case(11, 1'b1, 1'b1);
    edge_case(10, 1'b1, 1'b0);
    // unmapped address answers with an error
    xfer(1'b0, 8'h40, 32'h0);
    chk("slverr", {31'h0, rerr}, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
